// File: rtl/smbsl_defines.vh
// Function
// - Answer only to fixed seven-bit slave address 0101110.
// - Byte is eight data bits MSB first then one acknowledge bit.
// - Data changes only while clock low; rising data with clock high is stop.
// - Direction set in address byte holds until a new start.
// - Accept one or two written bytes; supply exactly one read byte.
// - First byte after a write address loads the register pointer.
// - Second written byte is stored into the pointed register.
// - Read returns the pointed register; pointer is kept between reads.
// - Send byte: address with write, command byte sets pointer, each acked.
// - Write byte: address, command, data; device acks all three.
// - Receive byte: ack read address, drive pointed byte, master nacks.
// - Read byte: pointer write, repeated start, single-byte read.
// - Repeated start begins a new operation with a fresh address byte.
// - With timeout on, no bus activity for 35 ms releases the data line.
// - Bit 6 of configuration register one disables the timeout when set.
`ifndef SMBSL_DEFINES_VH
`define SMBSL_DEFINES_VH
`define SMBSL_SLAVE_ADDR   7'h2E
`define SMBSL_CFG1_IDX     8'h40
`define SMBSL_BUS_TIMEOUT_DISABLE_BIT    6
`define SMBSL_CFG1_RESET   8'h00
`define SMBSL_TIMEOUT_MS   35
`define SMBSL_CLK_HZ       40000000
`define SMBSL_TIMEOUT_CYC  ((`SMBSL_CLK_HZ / 1000) * `SMBSL_TIMEOUT_MS)
`define SMBSL_PTR_RESET    8'h00
`endif

// File: rtl/smbsl_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "smbsl_defines.vh"

// =====================================================================
// SMBus slave: pointer register, 256-entry byte register file, timeout
//
// Overview of behaviour
// - Both bus lines are sampled by the core clock, never used as clocks.
// - Every pin edge is seen four to five core cycles late.
// - The bus clock must stay low long enough to cover that latency;
//   a low phase under about eight core cycles is not supported.
// - The data line is open drain: sda_out is always low and sda_oe
//   decides whether the line is pulled down.
// - Address byte: seven address bits then the direction bit.
// - Only the fixed slave address is acknowledged.
// - Write: first byte loads the pointer, second byte is stored.
// - A third written byte is not acknowledged; the engine goes idle.
// - Read: one byte from the pointed register, then the line is let go.
// - The pointer is kept across stop and repeated start, so a later
//   read needs no fresh pointer write.
// - Start or stop in the middle of a byte throws the partial byte away.
// - A bus parked with no edges for the timeout interval releases the
//   data line, unless the disable bit of configuration one is set.
//
// Hazards and limits
// - The register file has no reset; reading an unwritten index returns
//   whatever the memory powered up with.
// - Configuration one is mirrored in a flop so the timeout logic does
//   not need a second read port on the memory.
// - The idle counter saturates rather than wraps, so a very long park
//   with the timeout disabled can never fire a late, false timeout.
// - No clock stretching: the engine keeps up only with a master that meets the low-phase limit above.
// =====================================================================
module smbsl_slave #(
  parameter TIMEOUT_CYC = `SMBSL_TIMEOUT_CYC
) (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  output reg  [7:0] ptr_out,
  output reg        wr_strobe,
  output reg  [7:0] wr_addr,
  output reg  [7:0] wr_data,
  output reg        timeout_flag
);

  // States, one-hot
  localparam [5:0] ST_IDLE = 6'b00_0001;
  localparam [5:0] ST_ADDR = 6'b00_0010;
  localparam [5:0] ST_RXB  = 6'b00_0100;
  localparam [5:0] ST_ACK  = 6'b00_1000;
  localparam [5:0] ST_TXB  = 6'b01_0000;
  localparam [5:0] ST_MACK = 6'b10_0000;

  // =====================================================================
  // Input synchronisers: three flops, change accepted when 2nd and 3rd agree
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg       scl_reg;
  reg       sda_reg;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_reg <= 3'b111;
      sda_sync_reg <= 3'b111;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_reg <= sda_sync_reg[2];
    end
  end

  reg  scl_d_reg;
  reg  sda_d_reg;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_reg;
      sda_d_reg <= sda_reg;
    end
  end

  // =====================================================================
  // Edge decoding, shared by the clock edges and the bus conditions

  // Edge of one synchronised line; rising selects the direction
  function smbsl_edge;
    input now_lvl;
    input prev_lvl;
    input rising;
    begin
      if (rising)
        smbsl_edge = now_lvl & ~prev_lvl;
      else
        smbsl_edge = ~now_lvl & prev_lvl;
    end
  endfunction

  // Data edge while the clock stayed high for two samples
  // Requiring two high samples keeps a data change that races the
  // clock's own edge from being taken for a start or a stop
  function smbsl_cond;
    input scl_now;
    input scl_prev;
    input sda_now;
    input sda_prev;
    input rising;
    begin
      smbsl_cond = scl_now & scl_prev &
                   smbsl_edge(sda_now, sda_prev, rising);
    end
  endfunction

  wire scl_rise = smbsl_edge(scl_reg, scl_d_reg, 1'b1);
  wire scl_fall = smbsl_edge(scl_reg, scl_d_reg, 1'b0);
  wire start_det = smbsl_cond(scl_reg, scl_d_reg, sda_reg, sda_d_reg, 1'b0);
  wire stop_det  = smbsl_cond(scl_reg, scl_d_reg, sda_reg, sda_d_reg, 1'b1);
  wire bus_act   = scl_rise | scl_fall | (sda_reg ^ sda_d_reg);

  // =====================================================================
  // Register file and state
  reg [7:0]  regs_mem [0:255];
  reg [5:0]  state_reg;
  reg [3:0]  bit_cnt_reg;
  reg [7:0]  shift_reg;
  reg        rnw_reg;
  reg [1:0]  wbyte_cnt_reg;
  reg [7:0]  cfg1_reg;
  reg [31:0] idle_cnt_reg;

  // Timeout enabled unless disable bit set
  // timeout disable
  wire to_enable = ~cfg1_reg[`SMBSL_BUS_TIMEOUT_DISABLE_BIT];
  wire to_hit = to_enable && (idle_cnt_reg >= TIMEOUT_CYC - 1) &&
                (state_reg != ST_IDLE);

  // Idle counter: restarts on any line activity
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt_reg <= 32'h0000_0000;
    end else if (bus_act || state_reg == ST_IDLE) begin
      idle_cnt_reg <= 32'h0000_0000;
    end else if (idle_cnt_reg != 32'hFFFF_FFFF) begin
      idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
    end
  end

  // Configuration register one is written through the bus like others;
  // mirrored here because the timeout logic reads it every cycle
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg1_reg <= `SMBSL_CFG1_RESET;
    end else if (wr_strobe && wr_addr == `SMBSL_CFG1_IDX) begin
      cfg1_reg <= wr_data;
    end
  end

  // Memory write port; no reset, contents are don't-care after power-up
  always @(posedge ref_clk) begin
    if (wr_strobe)
      regs_mem[wr_addr] <= wr_data;
  end

  // =====================================================================
  // Protocol engine
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      rnw_reg       <= 1'b0;
      wbyte_cnt_reg <= 2'b00;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
      ptr_out       <= `SMBSL_PTR_RESET;
      wr_strobe     <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 8'h00;
      timeout_flag  <= 1'b0;
    end else begin
      wr_strobe    <= 1'b0;
      timeout_flag <= 1'b0;
      sda_out      <= 1'b0;
      if (start_det) begin
        // fresh address after start; aborts a partial byte
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe      <= 1'b0;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end else if (to_hit) begin
        state_reg    <= ST_IDLE;
        sda_oe       <= 1'b0;
        timeout_flag <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_RXB: begin
            // sample MSB first on rising clock
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_reg};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == `SMBSL_SLAVE_ADDR) begin
                  rnw_reg       <= shift_reg[0];
                  wbyte_cnt_reg <= 2'b00;
                  state_reg     <= ST_ACK;
                  sda_oe        <= 1'b1;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (wbyte_cnt_reg == 2'b00) begin
                // first byte is pointer; send byte
                ptr_out       <= shift_reg;
                wbyte_cnt_reg <= 2'b01;
                state_reg     <= ST_ACK;
                sda_oe        <= 1'b1;
              end else if (wbyte_cnt_reg == 2'b01) begin
                wr_strobe     <= 1'b1;
                wr_addr       <= ptr_out;
                wr_data       <= shift_reg;
                wbyte_cnt_reg <= 2'b10;
                state_reg     <= ST_ACK;
                sda_oe        <= 1'b1;
              end else begin
                // third byte refused, line left released
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            // Ack held across the ninth pulse; on its falling edge released for a write, set from data bit 7 for a read
            if (scl_fall) begin
              if (rnw_reg) begin
                shift_reg   <= regs_mem[ptr_out];
                sda_oe      <= ~regs_mem[ptr_out][7];
                bit_cnt_reg <= 4'h1;
                state_reg   <= ST_TXB;
              end else begin
                sda_oe    <= 1'b0;
                state_reg <= ST_RXB;
              end
            end
          end
          ST_TXB: begin
            // Open drain: enable low bits only; shift on falling clock
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                sda_oe    <= 1'b0;
                state_reg <= ST_MACK;
              end else begin
                sda_oe      <= ~shift_reg[6];
                shift_reg   <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_MACK: begin
            // one byte only; further pulses get no data
            if (scl_fall)
              state_reg <= ST_IDLE;
          end
          default: begin
            state_reg <= ST_IDLE;
            sda_oe    <= 1'b0;
          end
        endcase
      end
    end
  end

  // combined read
  // The pointer survives a repeated start, so a pointer write followed
  // by a repeated start and a read needs no extra logic here.

endmodule
`default_nettype wire

// File: test/smbsl_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================
// Port checker for the bus slave
module smbsl_chk #(
  parameter TIMEOUT_CYC = 200
) (
  input wire       ref_clk,
  input wire       nrst,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire [7:0] ptr_out,
  input wire       wr_strobe,
  input wire [7:0] wr_addr,
  input wire       timeout_flag
);
  reg [31:0] quiet_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Raw-pin quiet time; the slave lags it by its synchroniser
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      quiet_reg <= 32'h0000_0000;
    else if ($changed(scl_in) || $changed(sda_in))
      quiet_reg <= 32'h0000_0000;
    else
      quiet_reg <= quiet_reg + 32'h0000_0001;
  end
  property p_oe_move; $changed(sda_oe) |-> !scl_in; endproperty
  a_oe_move: assert property (p_oe_move) else $error("oe moved");
  property p_out0; sda_out == 1'b0; endproperty
  a_out0: assert property (p_out0) else $error("drove high");
  property p_oe_hold; sda_oe && scl_in |=> sda_oe; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe dropped");
  property p_wr_ack; wr_strobe |-> ##[0:8] sda_oe; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write no ack");
  property p_wr_ptr; wr_strobe |-> wr_addr == ptr_out; endproperty
  a_wr_ptr: assert property (p_wr_ptr) else $error("write index");
  property p_ptr_ack; $changed(ptr_out) |-> ##[0:8] sda_oe; endproperty
  a_ptr_ack: assert property (p_ptr_ack) else $error("ptr no ack");
  property p_to_rel; timeout_flag |-> ##[0:2] !sda_oe; endproperty
  a_to_rel: assert property (p_to_rel) else $error("no release");
  property p_to_quiet; timeout_flag |-> quiet_reg >= TIMEOUT_CYC - 8;
  endproperty
  a_to_quiet: assert property (p_to_quiet) else $error("early");
  c_wr: cover property (wr_strobe);
  c_to: cover property (timeout_flag);
  c_ptr: cover property ($changed(ptr_out));
endmodule
bind smbsl_slave smbsl_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .ptr_out(ptr_out),
  .wr_strobe(wr_strobe), .wr_addr(wr_addr), .timeout_flag(timeout_flag));
`default_nettype wire

// File: test/smbsl_mst.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================
// Master model; long low phase so the slave sees each edge
module smbsl_mst (
  output reg  scl,
  output reg  sda_m,
  input  wire sda
);
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  task cond(input v);
    begin
      if (!scl) begin
        sda_m = !v;
        #200 scl = 1'b1;
        #200;
      end
      sda_m = v;
      #200;
      if (!v) scl = 1'b0;
      #100;
    end
  endtask
  // n bits MSB first, data set while clock low
  task xbyte(input [8:0] tx, input integer n, output [8:0] rx);
    integer i;
    begin
      rx = 9'h1ff;
      for (i = 8; i > 8 - n; i = i - 1) begin
        sda_m = tx[i];
        #200 scl = 1'b1;
        #100 rx[i] = sda;
        #100 scl = 1'b0;
        #100;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks = n_checks + 1; if ((a) !== (b)) begin \
  err_count = err_count + 1; $display("BAD %0t mismatch", $time); end end
// ====================================
// Bench: master model against the slave
module tb_top;
  localparam TO = 200;
  reg         ref_clk = 1'b0;
  reg         nrst    = 1'b0;
  wire        scl, sda_m, sda, sda_out, sda_oe, wr_strobe, timeout_flag;
  wire [7:0]  ptr_out, wr_addr, wr_data;
  reg  [8:0]  rx;
  reg  [7:0]  a, d, a2, d2;
  reg  [15:0] expq [$];
  integer     err_count = 0, n_checks = 0, seed = 32'h13c4_20ae, i, k;
  // Pull-up on data: a released line reads high
  assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
  always #12.5 ref_clk = ~ref_clk;
  smbsl_mst mst (.scl(scl), .sda_m(sda_m), .sda(sda));
  smbsl_slave #(.TIMEOUT_CYC(TO)) dut (.ref_clk(ref_clk), .nrst(nrst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .ptr_out(ptr_out), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data), .timeout_flag(timeout_flag));
  task conclude;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // One byte out, then the ack slot
  task sb(input [7:0] b, input ack);
    begin
      mst.xbyte({b, 1'b1}, 9, rx);
      `CHK(rx[0], !ack)
    end
  endtask
  // Write address then pointer byte
  task ptr(input [7:0] p);
    begin
      mst.cond(1'b0);
      sb(8'h5c, 1'b1);
      sb(p, 1'b1);
      `CHK(ptr_out, p)
    end
  endtask
  // Receive byte; released ack slot is the nack
  task rd(input [7:0] e);
    begin
      mst.cond(1'b0);
      sb(8'h5d, 1'b1);
      mst.xbyte(9'h1ff, 9, rx);
      `CHK(rx[8:1], e)
      mst.cond(1'b1);
    end
  endtask
  task wb(input [7:0] p, input [7:0] v);
    begin
      ptr(p);
      expq.push_back({p, v});
      sb(v, 1'b1);
    end
  endtask
  // Scoreboard: each write pulse against the oldest note
  always @(negedge ref_clk) begin
    if (wr_strobe === 1'b1) begin
      if (expq.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({wr_addr, wr_data}, expq.pop_front())
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    #2 nrst = 1'b1;
    repeat (8) @(posedge ref_clk);
    // Bit 6 kept clear so the config index stays untouched
    for (k = 0; k < 4; k = k + 1) begin
      a  = $random(seed) & 8'hbf;
      a2 = a ^ 8'h80;
      d  = $random(seed);
      d2 = $random(seed);
      wb(a, d);
      mst.cond(1'b1);
      wb(a2, d2);
      mst.cond(1'b1);
      ptr(a);
      mst.cond(1'b1);
      rd(d);
      rd(d);
      ptr(a2);
      rd(d2);
    end
    $display("test transfers done");
    for (k = 1; k < 8; k = k + 1) begin
      mst.cond(1'b0);
      sb(8'h5c ^ (8'h01 << k), 1'b0);
      sb(8'h00, 1'b0);
      mst.cond(1'b1);
    end
    wb(a, d);
    sb(8'h55, 1'b0);
    mst.cond(1'b1);
    ptr(a2);
    mst.xbyte(9'h000, 4, rx);
    mst.cond(1'b1);
    rd(d2);
    $display("test refusals done");
    // Clock parked low in an ack slot until the slave lets go
    mst.cond(1'b0);
    mst.xbyte(9'h0b8, 8, rx);
    for (i = 0; i < 4 * TO && timeout_flag !== 1'b1; i = i + 1)
      @(negedge ref_clk);
    `CHK(timeout_flag, 1'b1)
    if (timeout_flag !== 1'b1) conclude;
    repeat (3) @(negedge ref_clk);
    `CHK(sda_oe, 1'b0)
    mst.cond(1'b1);
    wb(8'h40, 8'h40);
    mst.cond(1'b1);
    mst.cond(1'b0);
    mst.xbyte(9'h0b8, 8, rx);
    repeat (3 * TO) @(negedge ref_clk);
    `CHK(sda_oe, 1'b1)
    mst.xbyte(9'h1ff, 1, rx);
    `CHK(rx[8], 1'b0)
    mst.cond(1'b1);
    `CHK(expq.size(), 0)
    $display("test timeout done");
    conclude;
  end
endmodule
`default_nettype wire
